/* File: bench/ntaf_ci_asserts.sv */
`timescale 1ns/10ps

// ----------------------------------------
// Serial frame checker
// ----------------------------------------
module ntaf_ci_asserts (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic frame_sync,
	input wire logic bit_stb,
	input wire logic cmd_ser,
	input wire logic ind_ser,
	input wire logic [3:0] CMD_CODE
);
	logic [9:0] gap_ff;
	logic [4:0] bits_ff;
	logic fseen_ff;
	logic sseen_ff;
	logic [3:0] code_ff;
	logic [4:0] cur;
	logic exp_bit;

	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	// Slot bit index of the bit that goes out one cycle after this strobe
	assign cur = frame_sync ? 5'h0 : bits_ff + 5'h1;
	// Field MSB is loaded from the code on the strobe cycle itself, before the latch below
	assign exp_bit = (cur == 5'd26) ? CMD_CODE[3] : code_ff[2'(5'd29 - cur)];

	// Gap counter, slot position and the code seen at the field start
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			gap_ff <= 10'h0;
			bits_ff <= 5'h0;
			fseen_ff <= 1'b0;
			sseen_ff <= 1'b0;
			code_ff <= 4'hf;
		end
		else
		begin
			gap_ff <= bit_stb ? 10'h0 : gap_ff + 10'h1;
			if (bit_stb)
			begin
				bits_ff <= cur;
				sseen_ff <= 1'b1;
			end
			if (frame_sync)
				fseen_ff <= 1'b1;
			if (bit_stb && cur == 5'd26)
				code_ff <= CMD_CODE;
		end
	end

	sequence s_strobe;
		bit_stb ##1 !bit_stb;
	endsequence

	property p_stb_pulse;
		$rose(bit_stb) |-> s_strobe;
	endproperty
	property p_fs_stb;
		frame_sync |-> bit_stb;
	endproperty
	property p_stb_gap;
		bit_stb && sseen_ff |-> gap_ff == 10'd780;
	endproperty
	property p_frame_len;
		frame_sync && fseen_ff |-> bits_ff == 5'd31;
	endproperty
	property p_cmd_hold;
		$changed(cmd_ser) |-> $past(bit_stb);
	endproperty
	property p_ind_hold;
		$changed(ind_ser) |-> bit_stb || $past(bit_stb);
	endproperty
	property p_idle;
		bit_stb && (fseen_ff || frame_sync) && (cur < 5'd26 || cur > 5'd29) |=> cmd_ser;
	endproperty
	property p_field;
		bit_stb && fseen_ff && cur >= 5'd26 && cur <= 5'd29 |=> cmd_ser == $past(exp_bit);
	endproperty

	a_stb_pulse: assert property (p_stb_pulse) else $error("bit strobe wider than one cycle");
	a_fs_stb: assert property (p_fs_stb) else $error("frame sync without bit strobe");
	a_stb_gap: assert property (p_stb_gap) else $error("bit period wrong");
	a_frame_len: assert property (p_frame_len) else $error("slot is not 32 bits");
	a_cmd_hold: assert property (p_cmd_hold) else $error("command line moved inside a bit");
	a_ind_hold: assert property (p_ind_hold) else $error("indication line moved inside a bit");
	a_idle: assert property (p_idle) else $error("command line not idle outside field");
	a_field: assert property (p_field) else $error("command field bit wrong");
endmodule // ntaf_ci_asserts

/* File: bench/test_nt_layer1_activation_fsm.sv */
`timescale 1ns/10ps

`define CHK(got, exp) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end

module test_nt_layer1_activation_fsm
	import ntaf_pkg::*;
;
	logic CLK;
	logic SYS_RST;
	logic [3:0] cmd_code;
	logic [3:0] up_ind;
	logic up_ind_new;
	logic rx_info0;
	logic rx_info3;
	logic rx_sync;
	logic code_viol;
	logic mf_end;
	logic viol_en;
	logic pulse_p;
	logic pulse_n;
	ntaf_txsig_t tx_signal;
	logic loop2;
	logic transp;
	logic [3:0] line_ind;
	logic [3:0] line_cmd;
	int failures;
	int n_checks;

	// ----------------------------------------
	// Both ends joined over one frame bus
	// ----------------------------------------
	ntaf_ci_if ci_bus();

	ntaf_up_end u_ntaf_up_end (.CLK(CLK), .SYS_RST(SYS_RST), .CMD_CODE(cmd_code), .IND_CODE(up_ind),
		.IND_NEW(up_ind_new), .ci(ci_bus));

	// Multiframe boundaries are pulsed by hand; real multiframe timing would not fit the run
	ntaf_line_end #(.SPT_PERIOD_CYC(17'd200)) u_ntaf_line_end (.CLK(CLK), .SYS_RST(SYS_RST),
		.RX_INFO0(rx_info0), .RX_INFO3(rx_info3), .RX_SYNC(rx_sync), .RX_CODE_VIOL(code_viol),
		.MULTIFRAME_END(mf_end), .VIOLATION_REPORT_EN(viol_en), .TX_SIGNAL(tx_signal), .TX_PULSE_P(pulse_p),
		.TX_PULSE_N(pulse_n), .LOOP2_CLOSED(loop2), .CHAN_TRANSPARENT(transp), .IND_CODE(line_ind),
		.CMD_CODE(line_cmd), .ci(ci_bus));

	ntaf_ci_asserts u_ntaf_ci_asserts (.CLK(CLK), .SYS_RST(SYS_RST), .frame_sync(ci_bus.frame_sync),
		.bit_stb(ci_bus.bit_stb), .cmd_ser(ci_bus.cmd_ser), .ind_ser(ci_bus.ind_ser), .CMD_CODE(cmd_code));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial
	begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	// Inputs move 1 ns after the edge so the design never races them
	task automatic step(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	task automatic test_done;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Codes need two full frames, so the bound covers a little over two
	task automatic wait_tx(input ntaf_txsig_t v, output int n);
		n = 0;
		while (tx_signal !== v && n < 60000)
		begin
			step(1);
			n++;
		end
		if (tx_signal !== v)
		begin
			failures++;
			test_done();
		end
	endtask

	task automatic wait_up_ind(input logic [3:0] v);
		int n;
		n = 0;
		while (up_ind !== v && n < 60000)
		begin
			step(1);
			n++;
		end
		`CHK(up_ind, v)
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		`CHK(tx_signal, TX_QUIET)
		`CHK(line_ind, 4'hf)
		`CHK(up_ind, 4'hf)
		`CHK(transp, 1'b0)
	endtask

	// One frame of a code is not enough; the second equal frame commits it
	task automatic t_activate;
		int n;
		cmd_code = 4'h8;
		wait_tx(TX_INFO2, n);
		`CHK(n > 24992, 1'b1)
		`CHK(line_cmd, 4'h8)
		`CHK(line_ind, 4'h8)
		`CHK(transp, 1'b0)
		rx_info3 = 1'b1;
		step(2);
		`CHK(line_ind, 4'hc)
		`CHK(tx_signal, TX_INFO2)
	endtask

	task automatic t_switch;
		int n;
		cmd_code = 4'hc;
		wait_tx(TX_INFO4, n);
		`CHK(transp, 1'b1)
		`CHK(loop2, 1'b0)
		`CHK(line_cmd, 4'hc)
		wait_up_ind(4'hc);
	endtask

	// Wake-up tone after sync loss from active must not disturb the lost-framing state
	task automatic t_lost;
		rx_sync = 1'b0;
		step(2);
		`CHK(line_ind, 4'h4)
		`CHK(tx_signal, TX_INFO2)
		`CHK(pulse_p, 1'b0)
		`CHK(pulse_n, 1'b0)
		rx_info0 = 1'b1;
		step(2);
		`CHK(line_ind, 4'h4)
		rx_sync = 1'b1;
		rx_info0 = 1'b0;
		step(2);
		`CHK(line_ind, 4'hc)
	endtask

	// A violation held until the multiframe end is reported only when enabled
	task automatic t_viol;
		code_viol = 1'b1;
		mf_end = 1'b1;
		step(1);
		code_viol = 1'b0;
		mf_end = 1'b0;
		`CHK(line_ind, 4'hc)
		viol_en = 1'b1;
		code_viol = 1'b1;
		step(1);
		code_viol = 1'b0;
		mf_end = 1'b1;
		step(1);
		mf_end = 1'b0;
		`CHK(line_ind, 4'hb)
		step(2);
		`CHK(line_ind, 4'hb)
	endtask

	// Mid-run reset, then a terminal wake-up: clock request is the first answer
	task automatic t_rearm;
		SYS_RST = 1'b1;
		step(10);
		SYS_RST = 1'b0;
		step(2);
		`CHK(line_ind, 4'hf)
		`CHK(up_ind, 4'hf)
		`CHK(line_cmd, 4'hf)
		`CHK(loop2, 1'b0)
		rx_info0 = 1'b1;
		step(1);
		`CHK(line_ind, 4'h0)
		`CHK(tx_signal, TX_QUIET)
	endtask

	initial
	begin
		SYS_RST = 1'b1;
		cmd_code = 4'hf;
		rx_info0 = 1'b0;
		rx_info3 = 1'b0;
		rx_sync = 1'b1;
		code_viol = 1'b0;
		mf_end = 1'b0;
		viol_en = 1'b0;
		failures = 0;
		n_checks = 0;
		step(10);
		SYS_RST = 1'b0;
		step(2);
		t_reset();
		t_activate();
		t_switch();
		t_lost();
		t_viol();
		t_rearm();
		test_done();
	end
endmodule // test_nt_layer1_activation_fsm

/* File: hw/ntaf_ci_if.sv */
`timescale 1ns/10ps

// Serial frame between upstream end (timing master) and the line end
interface ntaf_ci_if;
	logic frame_sync;
	logic bit_stb;
	logic cmd_ser;
	logic ind_ser;

	modport dev (input frame_sync, input bit_stb, input cmd_ser, output ind_ser);
	modport up (output frame_sync, output bit_stb, output cmd_ser, input ind_ser);
endinterface

/* File: hw/ntaf_defs.svh */
`ifndef NTAF_DEFS_SVH
`define NTAF_DEFS_SVH

// ----------------------------------------
// Clock and frame timing
// ----------------------------------------
`define NTAF_CLK_PERIOD_NS 5
`define NTAF_CLK_HZ 200000000
`define NTAF_FRAME_NS 125000
`define NTAF_SLOT_BITS 32
`define NTAF_BIT_CYC (`NTAF_FRAME_NS / `NTAF_CLK_PERIOD_NS / `NTAF_SLOT_BITS)
`define NTAF_DEACT_TMO_MS 32
`define NTAF_DEACT_TMO_FRAMES (`NTAF_DEACT_TMO_MS * 1000000 / `NTAF_FRAME_NS)
`define NTAF_TIMING_FRAMES 4
`define NTAF_CVR_REPEAT 6
`define NTAF_SPT_HZ 2000
`define NTAF_CPT_HZ 96000
`define NTAF_SPT_CYC (`NTAF_CLK_HZ / `NTAF_SPT_HZ)
`define NTAF_CPT_CYC (`NTAF_CLK_HZ / `NTAF_CPT_HZ)

// ----------------------------------------
// Command/indicate field layout
// ----------------------------------------
`define NTAF_CI_FIRST 5'd26
`define NTAF_CI_LAST 5'd29
`define NTAF_CI_DONE 5'd30
`define NTAF_SLOT_LAST 5'd31
`define NTAF_IDLE_BIT 1'b1

// ----------------------------------------
// Command codes, upstream to device
// ----------------------------------------
`define NTAF_CMD_DEACTIVATE_REQUEST 4'h0
`define NTAF_CMD_LAYER1_INIT 4'h1
`define NTAF_CMD_SINGLE_PULSE_TEST 4'h2
`define NTAF_CMD_CONTINUOUS_PULSE_TEST 4'h3
`define NTAF_CMD_RESYNC 4'h4
`define NTAF_CMD_ACTIVATE_REQUEST 4'h8
`define NTAF_CMD_ACTIVATE_LOOP_REQUEST 4'ha
`define NTAF_CMD_SWITCH_THROUGH 4'hc
`define NTAF_CMD_LOOP_SWITCH_THROUGH 4'he
`define NTAF_CMD_DEACTIVATE_CONFIRM 4'hf

// ----------------------------------------
// Indication codes, device to upstream
// ----------------------------------------
`define NTAF_IND_CLOCK_REQUEST 4'h0
`define NTAF_IND_RESYNC 4'h4
`define NTAF_IND_ACTIVATE_REQUEST 4'h8
`define NTAF_IND_FAR_CODE_VIOLATION 4'hb
`define NTAF_IND_ACTIVATION_INDICATE 4'hc
`define NTAF_IND_DEACTIVATED 4'hf

`endif

/* File: hw/ntaf_line_end.sv */
`timescale 1ns/10ps

// Behaviour
// - Deactivated: line quiet; clock request first
// - INFO 0 seen: indicate, await activate
// - Activate command: pending, send INFO 2
// - Loop activate in pending closes loop 2
// - INFO 3 seen: keep INFO 2, await switch
// - Switch-through: active, INFO 4, channels transparent
// - Loop switch-through closes loop 2 when active
// - Receiver sync loss while active: lost framing
// - Resync command: send INFO 2
// - Deactivate: pending until INFO 0 or 32 ms
// - Then wait for deactivate confirm command
// - Single pulse test: alternating pulses, 2 kHz
// - Continuous pulse test: alternating pulses, 96 kHz
// - Code field: 4 bits at slot bits 26-29
// - New code valid after two equal frames
// - Upstream holds a command until acted on
// - Indication follows current state; while active also a pending violation report
// - Command code table for this mode
// - Indication code table for this mode
// - Enabled: violation indicated six frames per multiframe
// - Confirm returns to deactivated, INFO 0 armed

module ntaf_line_end
	import ntaf_pkg::*;
#(
	parameter logic [16:0] SPT_PERIOD_CYC = 17'(`NTAF_SPT_CYC)
)
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic RX_INFO0,
	input wire logic RX_INFO3,
	input wire logic RX_SYNC,
	input wire logic RX_CODE_VIOL,
	input wire logic MULTIFRAME_END,
	input wire logic VIOLATION_REPORT_EN,
	output ntaf_txsig_t TX_SIGNAL,
	output logic TX_PULSE_P,
	output logic TX_PULSE_N,
	output logic LOOP2_CLOSED,
	output logic CHAN_TRANSPARENT,
	output logic [3:0] IND_CODE,
	output logic [3:0] CMD_CODE,
	ntaf_ci_if.dev ci
);

	ntaf_dev_state_t r_ff;
	ntaf_dev_state_t nxt_r;
	logic frame_tick;
	logic cmd_ok;
	logic [3:0] cmd;
	logic [16:0] period;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	// Codes not listed for this mode are dropped here, so no state moves on them
	function automatic logic cmd_defined(input logic [3:0] c);
		return (c == `NTAF_CMD_DEACTIVATE_REQUEST) || (c == `NTAF_CMD_LAYER1_INIT) ||
			(c == `NTAF_CMD_SINGLE_PULSE_TEST) || (c == `NTAF_CMD_CONTINUOUS_PULSE_TEST) ||
			(c == `NTAF_CMD_RESYNC) || (c == `NTAF_CMD_ACTIVATE_REQUEST) ||
			(c == `NTAF_CMD_ACTIVATE_LOOP_REQUEST) || (c == `NTAF_CMD_SWITCH_THROUGH) ||
			(c == `NTAF_CMD_LOOP_SWITCH_THROUGH) || (c == `NTAF_CMD_DEACTIVATE_CONFIRM);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.pulse_p = 1'b0;
		nxt_r.pulse_n = 1'b0;
		frame_tick = 1'b0;

		// Serial slot: shift the command in, the indication out
		if (ci.bit_stb)
		begin
			nxt_r.idx = ci.frame_sync ? 5'h0 : 5'(r_ff.idx + 5'h1);
			if (ntaf_in_field(5'(nxt_r.idx - 5'h1)))
				nxt_r.rx_sh = {r_ff.rx_sh[2:0], ci.cmd_ser};
			if (nxt_r.idx == `NTAF_CI_FIRST)
			begin
				nxt_r.ser = r_ff.ind[3];
				nxt_r.tx_sh = {r_ff.ind[2:0], 1'b1};
			end
			else if (ntaf_in_field(nxt_r.idx))
			begin
				nxt_r.ser = r_ff.tx_sh[3];
				nxt_r.tx_sh = {r_ff.tx_sh[2:0], 1'b1};
			end
			else
				nxt_r.ser = `NTAF_IDLE_BIT;
			if (nxt_r.idx == `NTAF_CI_DONE)
			begin
				frame_tick = 1'b1;
				nxt_r.rx_prev = nxt_r.rx_sh;
				// Single-frame glitches never reach the state machine
				if (nxt_r.rx_sh == r_ff.rx_prev)
					nxt_r.cmd = nxt_r.rx_sh;
			end
		end

		// Frame counter, shared by the clock request hold and the 32 ms timer
		if (frame_tick && (r_ff.frames != 9'h1ff))
			nxt_r.frames = 9'(r_ff.frames + 9'h1);

		// Violation report; an error on the boundary cycle still counts
		if (MULTIFRAME_END)
		begin
			if ((r_ff.viol || RX_CODE_VIOL) && VIOLATION_REPORT_EN)
				nxt_r.cvr_cnt = 3'(`NTAF_CVR_REPEAT);
			nxt_r.viol = 1'b0;
		end
		else
		begin
			if (RX_CODE_VIOL)
				nxt_r.viol = 1'b1;
			if (frame_tick && (r_ff.cvr_cnt != 3'h0))
				nxt_r.cvr_cnt = 3'(r_ff.cvr_cnt - 3'h1);
		end

		// Commands act while held; nothing is latched from a single frame
		cmd = r_ff.cmd;
		cmd_ok = cmd_defined(cmd);
		if (cmd_ok && (cmd == `NTAF_CMD_LAYER1_INIT))
			nxt_r.st = ST_DEACT;
		else if (cmd_ok && (cmd == `NTAF_CMD_DEACTIVATE_REQUEST) && (r_ff.st != ST_DEACT) &&
			(r_ff.st != ST_PEND_DEACT) && (r_ff.st != ST_WAIT_CONFIRM))
			nxt_r.st = ST_PEND_DEACT;
		else if (cmd_ok && (cmd == `NTAF_CMD_SINGLE_PULSE_TEST))
			nxt_r.st = ST_SPT;
		else if (cmd_ok && (cmd == `NTAF_CMD_CONTINUOUS_PULSE_TEST))
			nxt_r.st = ST_CPT;
		else
		begin
			case (r_ff.st)
				ST_DEACT:
					if (RX_INFO0)
						nxt_r.st = ST_TIMING;
					else if ((cmd == `NTAF_CMD_ACTIVATE_REQUEST) || (cmd == `NTAF_CMD_ACTIVATE_LOOP_REQUEST))
						nxt_r.st = ST_PEND_ACT;
				ST_TIMING:
					if (r_ff.frames >= 9'(`NTAF_TIMING_FRAMES))
						nxt_r.st = ST_INFO0_SEEN;
				ST_INFO0_SEEN:
					if ((cmd == `NTAF_CMD_ACTIVATE_REQUEST) || (cmd == `NTAF_CMD_ACTIVATE_LOOP_REQUEST))
						nxt_r.st = ST_PEND_ACT;
				ST_PEND_ACT:
					if (RX_INFO3)
						nxt_r.st = ST_WAIT_SWITCH;
				ST_WAIT_SWITCH:
					if ((cmd == `NTAF_CMD_SWITCH_THROUGH) || (cmd == `NTAF_CMD_LOOP_SWITCH_THROUGH))
						nxt_r.st = ST_ACTIVE;
				ST_ACTIVE:
					if (!RX_SYNC)
						nxt_r.st = ST_LOST_LINE;
					else if (cmd == `NTAF_CMD_RESYNC)
						nxt_r.st = ST_LOST_UP;
				ST_LOST_LINE:
					if (RX_INFO3 && RX_SYNC)
						nxt_r.st = ST_ACTIVE;
				ST_LOST_UP:
					if (!RX_SYNC)
						nxt_r.st = ST_LOST_LINE;
					else if ((cmd == `NTAF_CMD_SWITCH_THROUGH) || (cmd == `NTAF_CMD_LOOP_SWITCH_THROUGH))
						nxt_r.st = ST_ACTIVE;
				ST_PEND_DEACT:
					// Unstable: left on either terminal silence or timer expiry
					if (RX_INFO0 || (r_ff.frames >= 9'(`NTAF_DEACT_TMO_FRAMES)))
						nxt_r.st = ST_WAIT_CONFIRM;
				ST_WAIT_CONFIRM:
					if (cmd == `NTAF_CMD_DEACTIVATE_CONFIRM)
						nxt_r.st = ST_DEACT;
				ST_SPT, ST_CPT:
					nxt_r.st = r_ff.st;
				default:
					nxt_r.st = ST_DEACT;
			endcase
		end

		// Timer restarts on every state entry
		if (nxt_r.st != r_ff.st)
			nxt_r.frames = 9'h0;

		// Loop 2 follows the loop variant of the command that holds the state
		case (nxt_r.st)
			ST_PEND_ACT, ST_WAIT_SWITCH:
				if (cmd == `NTAF_CMD_ACTIVATE_LOOP_REQUEST)
					nxt_r.loop2 = 1'b1;
				else if (cmd == `NTAF_CMD_ACTIVATE_REQUEST)
					nxt_r.loop2 = 1'b0;
			ST_ACTIVE, ST_LOST_LINE, ST_LOST_UP:
				if (cmd == `NTAF_CMD_LOOP_SWITCH_THROUGH)
					nxt_r.loop2 = 1'b1;
				else if (cmd == `NTAF_CMD_SWITCH_THROUGH)
					nxt_r.loop2 = 1'b0;
			default:
				nxt_r.loop2 = 1'b0;
		endcase

		// Line signal and indication follow the state; while active the indication also shows a pending violation report
		nxt_r.transp = 1'b0;
		case (nxt_r.st)
			ST_TIMING, ST_PEND_DEACT:
			begin
				nxt_r.tx_sig = TX_QUIET;
				nxt_r.ind = `NTAF_IND_CLOCK_REQUEST;
			end
			ST_INFO0_SEEN:
			begin
				nxt_r.tx_sig = TX_QUIET;
				nxt_r.ind = `NTAF_IND_ACTIVATE_REQUEST;
			end
			ST_PEND_ACT:
			begin
				nxt_r.tx_sig = TX_INFO2;
				nxt_r.ind = `NTAF_IND_ACTIVATE_REQUEST;
			end
			ST_WAIT_SWITCH, ST_LOST_UP:
			begin
				nxt_r.tx_sig = TX_INFO2;
				nxt_r.ind = `NTAF_IND_ACTIVATION_INDICATE;
			end
			ST_ACTIVE:
			begin
				nxt_r.tx_sig = TX_INFO4;
				nxt_r.transp = 1'b1;
				nxt_r.ind = (nxt_r.cvr_cnt != 3'h0) ? `NTAF_IND_FAR_CODE_VIOLATION
					: `NTAF_IND_ACTIVATION_INDICATE;
			end
			ST_LOST_LINE:
			begin
				nxt_r.tx_sig = TX_INFO2;
				nxt_r.ind = `NTAF_IND_RESYNC;
			end
			ST_SPT, ST_CPT:
			begin
				nxt_r.tx_sig = TX_TEST;
				nxt_r.ind = `NTAF_IND_DEACTIVATED;
			end
			default:
			begin
				nxt_r.tx_sig = TX_QUIET;
				nxt_r.ind = `NTAF_IND_DEACTIVATED;
			end
		endcase

		// Test pulses, polarity alternates pulse to pulse
		period = (r_ff.st == ST_SPT) ? SPT_PERIOD_CYC : 17'(`NTAF_CPT_CYC);
		if ((r_ff.st == ST_SPT) || (r_ff.st == ST_CPT))
		begin
			if (r_ff.pcnt >= 17'(period - 17'h1))
			begin
				nxt_r.pcnt = 17'h0;
				nxt_r.pulse_p = ~r_ff.pol;
				nxt_r.pulse_n = r_ff.pol;
				nxt_r.pol = ~r_ff.pol;
			end
			else
				nxt_r.pcnt = 17'(r_ff.pcnt + 17'h1);
		end
		else
		begin
			nxt_r.pcnt = 17'h0;
			nxt_r.pol = 1'b0;
		end
	end

	// State register
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			r_ff <= '0;
			r_ff.st <= ST_DEACT;
			r_ff.ser <= `NTAF_IDLE_BIT;
			r_ff.cmd <= `NTAF_CMD_DEACTIVATE_CONFIRM;
			r_ff.rx_prev <= `NTAF_CMD_DEACTIVATE_CONFIRM;
			r_ff.ind <= `NTAF_IND_DEACTIVATED;
			r_ff.tx_sig <= TX_QUIET;
		end
		else
			r_ff <= nxt_r;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign TX_SIGNAL = r_ff.tx_sig;
	assign TX_PULSE_P = r_ff.pulse_p;
	assign TX_PULSE_N = r_ff.pulse_n;
	assign LOOP2_CLOSED = r_ff.loop2;
	assign CHAN_TRANSPARENT = r_ff.transp;
	assign IND_CODE = r_ff.ind;
	assign CMD_CODE = r_ff.cmd;
	assign ci.ind_ser = r_ff.ser;

endmodule // ntaf_line_end

/* File: hw/ntaf_pkg.sv */
`include "ntaf_defs.svh"

package ntaf_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {ST_DEACT, ST_TIMING, ST_INFO0_SEEN, ST_PEND_ACT, ST_WAIT_SWITCH, ST_ACTIVE,
		ST_LOST_LINE, ST_LOST_UP, ST_PEND_DEACT, ST_WAIT_CONFIRM, ST_SPT, ST_CPT} ntaf_state_t;

	typedef enum logic [1:0] {TX_QUIET, TX_INFO2, TX_INFO4, TX_TEST} ntaf_txsig_t;

	typedef struct packed {
		ntaf_state_t st;
		logic [4:0] idx;
		logic [3:0] rx_sh;
		logic [3:0] rx_prev;
		logic [3:0] cmd;
		logic [3:0] ind;
		logic [3:0] tx_sh;
		logic ser;
		ntaf_txsig_t tx_sig;
		logic loop2;
		logic transp;
		logic [8:0] frames;
		logic [2:0] cvr_cnt;
		logic viol;
		logic [16:0] pcnt;
		logic pol;
		logic pulse_p;
		logic pulse_n;
	} ntaf_dev_state_t;

	typedef struct packed {
		logic [9:0] div;
		logic [4:0] idx;
		logic bit_stb;
		logic fsync;
		logic [3:0] tx_sh;
		logic ser;
		logic [3:0] rx_sh;
		logic [3:0] rx_prev;
		logic [3:0] ind;
		logic ind_new;
	} ntaf_up_state_t;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// True for slot positions carrying the command/indicate field
	function automatic logic ntaf_in_field(input logic [4:0] i);
		return (i >= `NTAF_CI_FIRST) && (i <= `NTAF_CI_LAST);
	endfunction

endpackage

/* File: hw/ntaf_up_end.sv */
`timescale 1ns/10ps

module ntaf_up_end
	import ntaf_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [3:0] CMD_CODE,
	output logic [3:0] IND_CODE,
	output logic IND_NEW,
	ntaf_ci_if.up ci
);

	ntaf_up_state_t r_ff;
	ntaf_up_state_t nxt_r;

	// ----------------------------------------
	// Frame timing, command send, indication check
	// ----------------------------------------
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.bit_stb = 1'b0;
		nxt_r.fsync = 1'b0;
		nxt_r.ind_new = 1'b0;
		// Bit divider; the whole slot timing is owned by this end
		if (r_ff.div == 10'(`NTAF_BIT_CYC - 1))
		begin
			nxt_r.div = 10'h0;
			nxt_r.bit_stb = 1'b1;
			nxt_r.idx = 5'(r_ff.idx + 5'h1);
			nxt_r.fsync = (nxt_r.idx == 5'h0);
			// Sample the previous bit one cycle before the far end drives the next one
			if (ntaf_in_field(5'(nxt_r.idx - 5'h1)))
				nxt_r.rx_sh = {r_ff.rx_sh[2:0], ci.ind_ser};
			if (nxt_r.idx == `NTAF_CI_DONE)
			begin
				nxt_r.rx_prev = nxt_r.rx_sh;
				if ((nxt_r.rx_sh == r_ff.rx_prev) && (nxt_r.rx_sh != r_ff.ind))
				begin
					nxt_r.ind = nxt_r.rx_sh;
					nxt_r.ind_new = 1'b1;
				end
			end
		end
		else
			nxt_r.div = 10'(r_ff.div + 10'h1);
		// Drive one cycle after the strobe so the far end samples a settled bit
		if (r_ff.bit_stb)
		begin
			if (r_ff.idx == `NTAF_CI_FIRST)
			begin
				nxt_r.ser = CMD_CODE[3];
				nxt_r.tx_sh = {CMD_CODE[2:0], 1'b1};
			end
			else if (ntaf_in_field(r_ff.idx))
			begin
				nxt_r.ser = r_ff.tx_sh[3];
				nxt_r.tx_sh = {r_ff.tx_sh[2:0], 1'b1};
			end
			else
				nxt_r.ser = `NTAF_IDLE_BIT;
		end
	end

	// State register
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			r_ff <= '0;
			r_ff.idx <= `NTAF_SLOT_LAST; // First tick opens slot bit 0
			r_ff.ser <= `NTAF_IDLE_BIT;
			r_ff.rx_prev <= `NTAF_IND_DEACTIVATED;
			r_ff.ind <= `NTAF_IND_DEACTIVATED;
		end
		else
			r_ff <= nxt_r;
	end

	assign ci.frame_sync = r_ff.fsync;
	assign ci.bit_stb = r_ff.bit_stb;
	assign ci.cmd_ser = r_ff.ser;
	assign IND_CODE = r_ff.ind;
	assign IND_NEW = r_ff.ind_new;

endmodule // ntaf_up_end
